// ---- hdl/ccr_pkg.sv ----
// constants, field layout and state type of the charger control-five and
// temperature control register bank.
// assumes an external two-wire serial engine presents byte accesses.
//
// Functional notes
// RQ1 - while ship switch not fitted, ocp, force-off and driver bits read 0, writes ignored
// RQ2 - after fitted is written 1, those ship bits become writable and the features active
// RQ3 - bit 5 gates discharge current sensing, default 0, watchdog and reset clear it
// RQ4 - bits 4-3 pick reverse mode discharge limit 3A/4A/5A/off, default 5A
// RQ5 - internal input limit enable, default 1, restored by watchdog or reset
// RQ6 - external pin input limit enable, default 1, restored only by register reset
// RQ7 - bit 0 enables discharge overcurrent protection, default 0, watchdog or reset clear
// RQ8 - control-five register reads 16h after reset
// RQ9 - register at 15h is reserved, read-only, reads zero
// RQ10 - bits 7-6 thermal regulation 60/80/100/120 C, default 120 C, watchdog restores
// RQ11 - bits 5-4 thermal shutdown 150/130/120/85 C, default 150 C, watchdog restores
// RQ12 - bit 3 bus pull-down enable, default 0, cleared only by register reset
// RQ13 - bit 2 first source pull-down enable, default 0, register reset only
// RQ14 - bit 1 second source pull-down enable, default 0, register reset only
// RQ15 - temperature control reads C0h after reset, bit 0 reserved and zero
// RQ16 - writes to reserved bits or reserved register do nothing, bits stay zero
// RQ17 - watchdog pulse restores watchdog fields only, register reset restores all fields

package ccr_pkg;

   localparam logic [7:0] CCR_OFS_CTRL5 = 8'h14;
   localparam logic [7:0] CCR_OFS_RSVD  = 8'h15;
   localparam logic [7:0] CCR_OFS_TEMP  = 8'h16;

   localparam logic [7:0] CCR_RST_CTRL5 = 8'h16;
   localparam logic [7:0] CCR_RST_TEMP  = 8'hC0;
   localparam logic [7:0] CCR_RD_ZERO   = 8'h00;

   // control-five bit positions
   localparam int CCR_B_FITTED = 7;
   localparam int CCR_B_SENSE  = 5;
   localparam int CCR_B_LIM_HI = 4;
   localparam int CCR_B_LIM_LO = 3;
   localparam int CCR_B_INTLIM = 2;
   localparam int CCR_B_EXTLIM = 1;
   localparam int CCR_B_OCP    = 0;

   // temperature control bit positions
   localparam int CCR_B_TREG_HI  = 7;
   localparam int CCR_B_TREG_LO  = 6;
   localparam int CCR_B_TSHUT_HI = 5;
   localparam int CCR_B_TSHUT_LO = 4;
   localparam int CCR_B_BUSPD    = 3;
   localparam int CCR_B_S1PD     = 2;
   localparam int CCR_B_S2PD     = 1;

   // reverse mode discharge limit codes
   localparam logic [1:0] CCR_LIM_3A  = 2'h0;
   localparam logic [1:0] CCR_LIM_4A  = 2'h1;
   localparam logic [1:0] CCR_LIM_5A  = 2'h2;
   localparam logic [1:0] CCR_LIM_OFF = 2'h3;

   // thermal codes
   localparam logic [1:0] CCR_TREG_120C  = 2'h3;
   localparam logic [1:0] CCR_TSHUT_150C = 2'h0;

   typedef struct packed {
      logic       fitted;
      logic       sense_en;
      logic [1:0] lim_sel;
      logic       int_lim_en;
      logic       ext_lim_en;
      logic       ocp_en;
      logic [1:0] treg_sel;
      logic [1:0] tshut_sel;
      logic       bus_pd;
      logic       s1_pd;
      logic       s2_pd;
      logic       force_off;
      logic [1:0] drv_ctrl;
      logic       pin_meta;
      logic       pin_sync;
      logic       ext_req;
      logic [7:0] rdata;
      logic       rvalid;
   } ccr_state_t;

   localparam ccr_state_t CCR_STATE_RST = '{
      fitted:     1'b0,
      sense_en:   1'b0,
      lim_sel:    CCR_LIM_5A,
      int_lim_en: 1'b1,
      ext_lim_en: 1'b1,
      ocp_en:     1'b0,
      treg_sel:   CCR_TREG_120C,
      tshut_sel:  CCR_TSHUT_150C,
      bus_pd:     1'b0,
      s1_pd:      1'b0,
      s2_pd:      1'b0,
      force_off:  1'b0,
      drv_ctrl:   2'h0,
      pin_meta:   1'b0,
      pin_sync:   1'b0,
      ext_req:    1'b0,
      rdata:      8'h00,
      rvalid:     1'b0
   };

endpackage

// ---- hdl/ccr_thermal_regs.sv ----
// register bank for charger control five, the reserved byte and
// temperature control, plus gating of the ship switch related controls.
// assumes the serial engine, watchdog and reset pulse sources run on sys_clk;
// only input_limit_pin comes from outside and is synchronised here.
`timescale 1ns/10ps

module ccr_thermal_regs (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic       wd_expire,
   input  wire logic       reg_reset,
   input  wire logic       ship_force_off_req,
   input  wire logic [1:0] ship_driver_req,
   input  wire logic       input_limit_pin,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   output logic            ship_switch_fitted,
   output logic            discharge_sense_en,
   output logic [1:0]      otg_discharge_limit_sel,
   output logic            internal_input_limit_en,
   output logic            external_input_limit_en,
   output logic            ext_limit_request,
   output logic            batt_discharge_ocp_en,
   output logic            ship_switch_force_off,
   output logic [1:0]      ship_driver_ctrl,
   output logic [1:0]      thermal_reg_sel,
   output logic [1:0]      thermal_shutdown_sel,
   output logic            bus_pulldown_en,
   output logic            source1_pulldown_en,
   output logic            source2_pulldown_en
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   ccr_pkg::ccr_state_t s_r;
   ccr_pkg::ccr_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // readback packing, shared by the read path and nowhere else duplicated

   function automatic logic [7:0] pack_ctrl5(
      input ccr_pkg::ccr_state_t st
   );
      logic [7:0] b;
      b = ccr_pkg::CCR_RD_ZERO;
      b[ccr_pkg::CCR_B_FITTED] = st.fitted;
      b[ccr_pkg::CCR_B_SENSE]  = st.sense_en;
      b[ccr_pkg::CCR_B_LIM_HI] = st.lim_sel[1];
      b[ccr_pkg::CCR_B_LIM_LO] = st.lim_sel[0];
      b[ccr_pkg::CCR_B_INTLIM] = st.int_lim_en;
      b[ccr_pkg::CCR_B_EXTLIM] = st.ext_lim_en;
      // locked at zero while no ship switch
      b[ccr_pkg::CCR_B_OCP]    = st.ocp_en & st.fitted; // RQ1
      return b;
   endfunction

   function automatic logic [7:0] pack_temp(
      input ccr_pkg::ccr_state_t st
   );
      logic [7:0] b;
      // bit 0 stays at the zero it starts with
      b = ccr_pkg::CCR_RD_ZERO; // RQ15
      b[ccr_pkg::CCR_B_TREG_HI]  = st.treg_sel[1];
      b[ccr_pkg::CCR_B_TREG_LO]  = st.treg_sel[0];
      b[ccr_pkg::CCR_B_TSHUT_HI] = st.tshut_sel[1];
      b[ccr_pkg::CCR_B_TSHUT_LO] = st.tshut_sel[0];
      b[ccr_pkg::CCR_B_BUSPD]    = st.bus_pd;
      b[ccr_pkg::CCR_B_S1PD]     = st.s1_pd;
      b[ccr_pkg::CCR_B_S2PD]     = st.s2_pd;
      return b;
   endfunction

   function automatic logic [7:0] read_mux(
      input ccr_pkg::ccr_state_t st,
      input logic [7:0]          a
   );
      logic [7:0] b;
      b = ccr_pkg::CCR_RD_ZERO;
      case (a)
         ccr_pkg::CCR_OFS_CTRL5: begin
            b = pack_ctrl5(st);
         end
         ccr_pkg::CCR_OFS_TEMP: begin
            b = pack_temp(st);
         end
         ccr_pkg::CCR_OFS_RSVD: begin
            b = ccr_pkg::CCR_RD_ZERO; // RQ9
         end
         default: begin
            b = ccr_pkg::CCR_RD_ZERO;
         end
      endcase
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt = s_r;

      // two flops before anything looks at the pin
      s_nxt.pin_meta = input_limit_pin;
      s_nxt.pin_sync = s_r.pin_meta;

      // read answer one cycle after the request; sees pre-write contents
      s_nxt.rvalid = reg_rd;
      if (reg_rd) begin
         s_nxt.rdata = read_mux(s_r, reg_addr); // RQ9
      end

      if (reg_reset) begin
         // every field back to default
         s_nxt.fitted     = ccr_pkg::CCR_STATE_RST.fitted; // RQ17
         s_nxt.sense_en   = ccr_pkg::CCR_STATE_RST.sense_en; // RQ3
         s_nxt.lim_sel    = ccr_pkg::CCR_STATE_RST.lim_sel; // RQ4
         s_nxt.int_lim_en = ccr_pkg::CCR_STATE_RST.int_lim_en; // RQ5
         s_nxt.ext_lim_en = ccr_pkg::CCR_STATE_RST.ext_lim_en; // RQ6
         s_nxt.ocp_en     = ccr_pkg::CCR_STATE_RST.ocp_en; // RQ7
         s_nxt.treg_sel   = ccr_pkg::CCR_STATE_RST.treg_sel; // RQ10
         s_nxt.tshut_sel  = ccr_pkg::CCR_STATE_RST.tshut_sel; // RQ11
         s_nxt.bus_pd     = ccr_pkg::CCR_STATE_RST.bus_pd; // RQ12
         s_nxt.s1_pd      = ccr_pkg::CCR_STATE_RST.s1_pd; // RQ13
         s_nxt.s2_pd      = ccr_pkg::CCR_STATE_RST.s2_pd; // RQ14
      end else if (wd_expire) begin
         // only watchdog fields; a write in the same cycle is dropped
         s_nxt.sense_en   = ccr_pkg::CCR_STATE_RST.sense_en; // RQ3
         s_nxt.lim_sel    = ccr_pkg::CCR_STATE_RST.lim_sel; // RQ4
         s_nxt.int_lim_en = ccr_pkg::CCR_STATE_RST.int_lim_en; // RQ5
         s_nxt.ocp_en     = ccr_pkg::CCR_STATE_RST.ocp_en; // RQ7
         s_nxt.treg_sel   = ccr_pkg::CCR_STATE_RST.treg_sel; // RQ10
         s_nxt.tshut_sel  = ccr_pkg::CCR_STATE_RST.tshut_sel; // RQ11
      end else if (reg_wr) begin
         case (reg_addr)
            ccr_pkg::CCR_OFS_CTRL5: begin
               s_nxt.fitted     = reg_wdata[ccr_pkg::CCR_B_FITTED]; // RQ2
               s_nxt.sense_en   = reg_wdata[ccr_pkg::CCR_B_SENSE]; // RQ3
               s_nxt.lim_sel    = reg_wdata[ccr_pkg::CCR_B_LIM_HI:ccr_pkg::CCR_B_LIM_LO]; // RQ4
               s_nxt.int_lim_en = reg_wdata[ccr_pkg::CCR_B_INTLIM]; // RQ5
               s_nxt.ext_lim_en = reg_wdata[ccr_pkg::CCR_B_EXTLIM]; // RQ6
               // unlock is judged on the value held before this write
               if (s_r.fitted) begin
                  s_nxt.ocp_en = reg_wdata[ccr_pkg::CCR_B_OCP]; // RQ2
               end
            end
            ccr_pkg::CCR_OFS_TEMP: begin
               s_nxt.treg_sel  = reg_wdata[ccr_pkg::CCR_B_TREG_HI:ccr_pkg::CCR_B_TREG_LO]; // RQ10
               s_nxt.tshut_sel = reg_wdata[ccr_pkg::CCR_B_TSHUT_HI:ccr_pkg::CCR_B_TSHUT_LO]; // RQ11
               s_nxt.bus_pd    = reg_wdata[ccr_pkg::CCR_B_BUSPD]; // RQ12
               s_nxt.s1_pd     = reg_wdata[ccr_pkg::CCR_B_S1PD]; // RQ13
               s_nxt.s2_pd     = reg_wdata[ccr_pkg::CCR_B_S2PD]; // RQ14
            end
            default: begin
               // reserved register and unmapped bytes take nothing
               s_nxt.rvalid = s_nxt.rvalid; // RQ16
            end
         endcase
      end

      // dropping the fitted bit relocks the ship controls at zero
      if (!s_nxt.fitted) begin
         s_nxt.ocp_en = 1'b0; // RQ1
      end

      // ship controls held elsewhere pass only once unlocked
      s_nxt.force_off = s_nxt.fitted & ship_force_off_req; // RQ1 RQ2
      s_nxt.drv_ctrl  = s_nxt.fitted ? ship_driver_req : 2'h0; // RQ1 RQ2

      // pin limiting only counts while its enable is set
      s_nxt.ext_req = s_nxt.ext_lim_en & s_r.pin_sync; // RQ6
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_r <= ccr_pkg::CCR_STATE_RST; // RQ8 RQ15
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from state flops

   assign reg_rdata               = s_r.rdata;
   assign reg_rvalid              = s_r.rvalid;
   assign ship_switch_fitted      = s_r.fitted;
   assign discharge_sense_en      = s_r.sense_en; // RQ3
   assign otg_discharge_limit_sel = s_r.lim_sel; // RQ4
   assign internal_input_limit_en = s_r.int_lim_en; // RQ5
   assign external_input_limit_en = s_r.ext_lim_en; // RQ6
   assign ext_limit_request       = s_r.ext_req;
   assign batt_discharge_ocp_en   = s_r.ocp_en; // RQ7
   assign ship_switch_force_off   = s_r.force_off;
   assign ship_driver_ctrl        = s_r.drv_ctrl;
   assign thermal_reg_sel         = s_r.treg_sel; // RQ10
   assign thermal_shutdown_sel    = s_r.tshut_sel; // RQ11
   assign bus_pulldown_en         = s_r.bus_pd; // RQ12
   assign source1_pulldown_en     = s_r.s1_pd; // RQ13
   assign source2_pulldown_en     = s_r.s2_pd; // RQ14

endmodule

// ---- verif/ccr_thermal_regs_properties.sv ----
// concurrent checks on the control-five / temperature register bank ports
// assumes single sys_clk domain; bound onto ccr_thermal_regs below
`timescale 1ns/10ps

module ccr_chk (
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       wd_expire,
   input wire logic       reg_reset,
   input wire logic       ship_force_off_req,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       ship_switch_fitted,
   input wire logic       discharge_sense_en,
   input wire logic [1:0] otg_discharge_limit_sel,
   input wire logic       internal_input_limit_en,
   input wire logic       external_input_limit_en,
   input wire logic       batt_discharge_ocp_en,
   input wire logic       ship_switch_force_off,
   input wire logic [1:0] thermal_reg_sel,
   input wire logic [1:0] thermal_shutdown_sel,
   input wire logic       bus_pulldown_en
);
   logic [7:0] wq_r;
   // write data one cycle late, to compare against fields after the write lands
   always_ff @(posedge sys_clk) begin
      wq_r <= reg_wdata;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_wr5;
      reg_wr && reg_addr == 8'h14 && !reg_reset && !wd_expire;
   endsequence
   property p_rsvd; s_rd(8'h15) |=> reg_rvalid && reg_rdata == 8'h00; endproperty
   property p_tb0; s_rd(8'h16) |=> reg_rvalid && !reg_rdata[0]; endproperty
   property p_ocp; !ship_switch_fitted |-> !batt_discharge_ocp_en; endproperty
   // force-off is registered from the fitted value of the same flop update, so judge it in the same cycle
   property p_gate; !ship_switch_fitted |-> !ship_switch_force_off; endproperty
   property p_pass; ship_switch_fitted |-> ship_switch_force_off == $past(ship_force_off_req); endproperty
   property p_wr5; s_wr5 |=> {ship_switch_fitted, discharge_sense_en, otg_discharge_limit_sel,
      internal_input_limit_en, external_input_limit_en} == {wq_r[7], wq_r[5:1]}; endproperty
   property p_wd; wd_expire |=> {discharge_sense_en, otg_discharge_limit_sel, internal_input_limit_en,
      batt_discharge_ocp_en, thermal_reg_sel, thermal_shutdown_sel} == {1'h0, 2'h2, 1'h1, 1'h0, 2'h3, 2'h0};
   endproperty
   property p_wdk; wd_expire && !reg_reset |=> $stable({external_input_limit_en, bus_pulldown_en}); endproperty
   property p_rr; reg_reset |=> {ship_switch_fitted, discharge_sense_en, otg_discharge_limit_sel,
      internal_input_limit_en, external_input_limit_en, batt_discharge_ocp_en, thermal_reg_sel,
      thermal_shutdown_sel, bus_pulldown_en} == {2'h0, 2'h2, 2'h3, 1'h0, 2'h3, 2'h0, 1'h0}; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved byte read not zero");
   a_tb0: assert property (p_tb0) else $error("temperature bit 0 read not zero");
   a_ocp: assert property (p_ocp) else $error("ocp set while switch not fitted");
   a_gate: assert property (p_gate) else $error("force-off set while not fitted");
   a_pass: assert property (p_pass) else $error("force-off not following request");
   a_wr5: assert property (p_wr5) else $error("control-five write not applied");
   a_wd: assert property (p_wd) else $error("watchdog fields not restored");
   a_wdk: assert property (p_wdk) else $error("watchdog touched reset-only field");
   a_rr: assert property (p_rr) else $error("register reset defaults wrong");
endmodule

bind ccr_thermal_regs ccr_chk u_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .wd_expire,
   .reg_reset, .ship_force_off_req, .reg_rdata, .reg_rvalid, .ship_switch_fitted, .discharge_sense_en,
   .otg_discharge_limit_sel, .internal_input_limit_en, .external_input_limit_en, .batt_discharge_ocp_en,
   .ship_switch_force_off, .thermal_reg_sel, .thermal_shutdown_sel, .bus_pulldown_en);

// ---- verif/testbench.sv ----
// self-checking bench for the control-five / temperature register bank
// assumes the byte register port of ccr_thermal_regs and a 100 MHz sys_clk
`timescale 1ns/10ps

module testbench;
   logic       sys_clk, sys_rst, reg_wr, reg_rd, wd_expire, reg_reset, ship_force_off_req, input_limit_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] ship_driver_req, otg_discharge_limit_sel, ship_driver_ctrl, thermal_reg_sel, thermal_shutdown_sel;
   logic       reg_rvalid, ship_switch_fitted, discharge_sense_en, internal_input_limit_en;
   logic       external_input_limit_en, ext_limit_request, batt_discharge_ocp_en, ship_switch_force_off;
   logic       bus_pulldown_en, source1_pulldown_en, source2_pulldown_en;
   int         failures, n_tests, i;
   // address, write data, expected readback; order matters, fitted state carries over
   localparam logic [23:0] ROWS [0:12] = '{24'h14FFBE, 24'h148181, 24'h140000, 24'h140808, 24'h141010,
      24'h141818, 24'h16FFFE, 24'h165A5A, 24'h16A4A4, 24'h163130, 24'h16C0C0, 24'h15FF00, 24'h20FF00};

   ccr_thermal_regs DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .wd_expire, .reg_reset,
      .ship_force_off_req, .ship_driver_req, .input_limit_pin, .reg_rdata, .reg_rvalid, .ship_switch_fitted,
      .discharge_sense_en, .otg_discharge_limit_sel, .internal_input_limit_en, .external_input_limit_en,
      .ext_limit_request, .batt_discharge_ocp_en, .ship_switch_force_off, .ship_driver_ctrl, .thermal_reg_sel,
      .thermal_shutdown_sel, .bus_pulldown_en, .source1_pulldown_en, .source2_pulldown_en);

   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk) reg_wr <= 1'h0;
   endtask

   // read answer is polled under a bound; running out ends the run as a mismatch
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int k;
      @(posedge sys_clk) reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk) reg_rd <= 1'h0;
      #1;
      for (k = 0; k < 4 && reg_rvalid !== 1'h1; k++) @(posedge sys_clk) #1;
      if (k == 4) begin
         failures++;
         tally_and_finish();
      end else begin
         chk8(reg_rdata, e);
      end
   endtask

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, reg_wr, reg_rd, wd_expire, reg_reset, ship_force_off_req, input_limit_pin} = 7'h40;
      {reg_addr, reg_wdata, ship_driver_req} = 18'h0;
      failures = 0;
      n_tests = 0;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'h0;
      rd(8'h14, 8'h16);
      rd(8'h16, 8'hC0);
      rd(8'h15, 8'h00);
      @(posedge sys_clk) #1 chk8({7'h00, reg_rvalid}, 8'h00);
      chk8({6'h00, otg_discharge_limit_sel}, 8'h02);
      $display("reset test done");
      for (i = 0; i < 13; i++) begin
         wr(ROWS[i][23:16], ROWS[i][15:8]);
         rd(ROWS[i][23:16], ROWS[i][7:0]);
      end
      $display("table test done");
      ship_force_off_req <= 1'h1;
      ship_driver_req <= 2'h3;
      wr(8'h14, 8'h80);
      repeat (2) @(posedge sys_clk);
      #1 chk8({5'h00, ship_switch_force_off, ship_driver_ctrl}, 8'h07);
      wr(8'h14, 8'h00);
      repeat (2) @(posedge sys_clk);
      #1 chk8({5'h00, ship_switch_force_off, ship_driver_ctrl}, 8'h00);
      $display("ship gating test done");
      wr(8'h14, 8'h80);
      wr(8'h14, 8'hFF);
      wr(8'h16, 8'hFE);
      @(posedge sys_clk) wd_expire <= 1'h1;
      @(posedge sys_clk) wd_expire <= 1'h0;
      rd(8'h14, 8'h96);
      rd(8'h16, 8'hCE);
      chk8({thermal_reg_sel, thermal_shutdown_sel, bus_pulldown_en, source1_pulldown_en, source2_pulldown_en, 1'h0},
         8'hCE);
      $display("watchdog test done");
      @(posedge sys_clk) reg_reset <= 1'h1;
      @(posedge sys_clk) reg_reset <= 1'h0;
      rd(8'h14, 8'h16);
      rd(8'h16, 8'hC0);
      chk8({thermal_reg_sel, thermal_shutdown_sel, bus_pulldown_en, source1_pulldown_en, source2_pulldown_en, 1'h0},
         8'hC0);
      $display("register reset test done");
      // pin passes two sync flops and the request flop before it shows
      input_limit_pin <= 1'h1;
      repeat (4) @(posedge sys_clk);
      #1 chk8({7'h00, ext_limit_request}, 8'h01);
      wr(8'h14, 8'h14);
      repeat (2) @(posedge sys_clk);
      #1 chk8({7'h00, ext_limit_request}, 8'h00);
      $display("input limit pin test done");
      tally_and_finish();
   end
endmodule
